/* hw/bebi_ctrl.sv */
// Purpose: Basic external bus interface cycle generator for ROM and SRAM.
// Assumes: All inputs but i_rst_n are synchronous to i_clk_sys; requests are aligned.
// Notes:   Internal masters issue one request at a time.
// Functional notes
// - One state per clock; cycles of 1-3 states.
// - On-chip memory: one state, 16-bit path.
// - Peripheral registers: two states, 8/16-bit path.
// - External: 8/16 bits, 2/3 states, waits 3-state.
// - 8-bit area: upper lane, word/long split bytewise.
// - 16-bit area: byte/word per cycle, long split.
// - 16-bit byte: even upper lane, odd lower.
// - Reads use one common read strobe.
// - Unused lane: ignored on read, released on write.
// - 8-bit area keeps lower write strobe high.
// - Two-state areas never get wait states.
// - Program waits and external wait pin supported.
// - Three-state area: 0-3 program waits per area.
// - Width bit: 0 is 16-bit, 1 is 8-bit.
// - State bit selects 2/3 states; two-bit wait count.
// - Low wait pin in the last second or wait state, after program waits, adds waits.
// - Power-on defaults; manual reset keeps settings.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module bebi_ctrl
    import bebi_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_manual_rst,
    input  wire logic        i_req,
    input  wire logic [1:0]  i_space,
    input  wire logic        i_periph_wide,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic [1:0]  i_size,
    input  wire logic [31:0] i_wdata,
    output logic             o_busy,
    output logic             o_done,
    output logic [31:0]      o_rdata,
    output logic             o_int_sel,
    output logic             o_int_we,
    input  wire logic [15:0] i_int_rdata,
    output logic [23:0]      o_addr,
    output logic             o_rd_n,
    output logic             o_upper_write_strobe_n,
    output logic             o_lower_write_strobe_n,
    output logic [15:0]      o_data,
    output logic             o_data_oe_hi,
    output logic             o_data_oe_lo,
    input  wire logic [15:0] i_data,
    input  wire logic        i_wait_n,
    input  wire logic [2:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic [7:0]       o_reg_rdata
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        bebi_state_t st;
        logic        w8;
        logic        three;
        logic        one;
        logic [1:0]  nwait;
        logic [1:0]  wcnt;
        logic        pinw;
        logic        ext;
        logic        unit2;
        logic [2:0]  nbytes;
        logic [2:0]  boff;
        logic [23:0] base;
        logic        wr;
        logic [1:0]  size;
        logic [31:0] wdat;
        logic [31:0] acc;
        logic [23:0] addr;
        logic        rd_n;
        logic        hwr_n;
        logic        lwr_n;
        logic [15:0] dout;
        logic        oe_hi;
        logic        oe_lo;
        logic        int_sel;
        logic        int_we;
        logic        busy;
        logic        done;
        logic [31:0] rdata;
        logic [7:0]  awc;
        logic [7:0]  asc;
        logic [7:0]  wch;
        logic [7:0]  wcl;
        logic        pwe;
        logic [7:0]  reg_rdata;
    } bebi_regs_t;

    localparam bebi_regs_t RST = '{
        st: ST_IDLE, rd_n: 1'b1, hwr_n: 1'b1, lwr_n: 1'b1,
        awc: AWC_RST, asc: ASC_RST, wch: WCH_RST, wcl: WCL_RST,
        pwe: PWE_RST, default: '0
    };

    bebi_regs_t r_ff;
    bebi_regs_t nxt_r;

    function automatic logic [7:0] byte_of(input logic [31:0] d,
                                           input logic [1:0]  j);
        byte_of = d[8*(3-j) +: 8];
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0]  area;
        logic [7:0]  wsel;
        logic [2:0]  bpc;
        logic [2:0]  nboff;
        logic [1:0]  k;
        logic [1:0]  klo;
        logic        a0;
        logic        hi_use;
        logic        lo_use;
        logic        cyc_end;
        logic [15:0] lane_in;
        logic [31:0] acc;
        logic [23:0] a;
        logic        act;
        area    = i_addr[AREA_LSB +: 3];
        wsel    = 8'h00;
        bpc     = 3'h1;
        nboff   = 3'h0;
        k       = 2'h0;
        klo     = 2'h0;
        a0      = 1'b0;
        hi_use  = 1'b0;
        lo_use  = 1'b0;
        cyc_end = 1'b0;
        lane_in = 16'h0000;
        acc     = 32'h0000_0000;
        a       = 24'h00_0000;
        act     = 1'b0;
        nxt_r   = r_ff;
        nxt_r.done = 1'b0;

        // Register port; settings are only ever changed by software.
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                REG_AREA_WIDTH_CONTROL: nxt_r.awc = i_reg_wdata;
                REG_AREA_STATE_CONTROL: nxt_r.asc = i_reg_wdata;
                REG_WAIT_COUNT_HIGH:    nxt_r.wch = i_reg_wdata;
                REG_WAIT_COUNT_LOW:     nxt_r.wcl = i_reg_wdata;
                REG_BUS_CONTROL:        nxt_r.pwe = i_reg_wdata[PWE_BIT];
                default:                ;
            endcase
        end
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                REG_AREA_WIDTH_CONTROL: nxt_r.reg_rdata = r_ff.awc;
                REG_AREA_STATE_CONTROL: nxt_r.reg_rdata = r_ff.asc;
                REG_WAIT_COUNT_HIGH:    nxt_r.reg_rdata = r_ff.wch;
                REG_WAIT_COUNT_LOW:     nxt_r.reg_rdata = r_ff.wcl;
                REG_BUS_CONTROL:        nxt_r.reg_rdata = {7'h00, r_ff.pwe};
                REG_STATUS:             nxt_r.reg_rdata =
                    {2'h0, r_ff.st, r_ff.ext, r_ff.wr, r_ff.busy};
                default:                nxt_r.reg_rdata = 8'h00;
            endcase
        end

        // Lanes of the cycle in progress.
        k   = r_ff.boff[1:0];
        a0  = r_ff.addr[0];
        klo = r_ff.unit2 ? k + 2'h1 : k;
        hi_use = r_ff.w8 | r_ff.unit2 | ~a0;
        lo_use = ~r_ff.w8 & (r_ff.unit2 | a0);
        bpc    = r_ff.unit2 ? 3'h2 : 3'h1;
        nboff  = r_ff.boff;

        unique case (r_ff.st)
            ST_IDLE: begin
                if (i_req) begin
                    nxt_r.base  = i_addr;
                    nxt_r.wr    = i_wr;
                    nxt_r.size  = i_size;
                    nxt_r.boff  = 3'h0;
                    nxt_r.wcnt  = 2'h0;
                    nxt_r.acc   = 32'h0000_0000;
                    nxt_r.ext   = (i_space == SPACE_EXT);
                    nxt_r.pinw  = r_ff.pwe;
                    nxt_r.nwait = 2'h0;
                    nxt_r.three = 1'b0;
                    unique case (i_space)
                        SPACE_ONCHIP: begin
                            nxt_r.w8  = 1'b0;
                            nxt_r.one = 1'b1;
                        end
                        SPACE_PERIPH: begin
                            nxt_r.w8  = ~i_periph_wide;
                            nxt_r.one = 1'b0;
                        end
                        default: begin
                            wsel = (area[2] ? r_ff.wch : r_ff.wcl)
                                   >> {area[1:0], 1'b0};
                            nxt_r.w8    = r_ff.awc[area];
                            nxt_r.three = r_ff.asc[area];
                            nxt_r.nwait = wsel[1:0];
                            nxt_r.one   = 1'b0;
                        end
                    endcase
                    nxt_r.unit2  = ~nxt_r.w8 & (i_size != SZ_BYTE);
                    nxt_r.nbytes = (i_size == SZ_LONG) ? 3'h4 :
                                   (i_size == SZ_WORD) ? 3'h2 : 3'h1;
                    unique case (i_size)
                        SZ_LONG: nxt_r.wdat = i_wdata;
                        SZ_WORD: nxt_r.wdat = {i_wdata[15:0], 16'h0000};
                        default: nxt_r.wdat = {i_wdata[7:0], 24'h00_0000};
                    endcase
                    nxt_r.st = ST_T1;
                end
            end
            ST_T1: begin
                if (r_ff.one) begin
                    cyc_end = 1'b1;
                end else begin
                    nxt_r.st = ST_SECOND_STATE;
                end
            end
            ST_SECOND_STATE, ST_WAIT_STATE: begin
                // Two-state areas leave here with no wait at all.
                if (!r_ff.three) begin
                    cyc_end = 1'b1;
                end else if (r_ff.wcnt < r_ff.nwait) begin
                    nxt_r.wcnt = r_ff.wcnt + 2'h1;
                    nxt_r.st   = ST_WAIT_STATE;
                end else if (r_ff.pinw && r_ff.ext && !i_wait_n) begin
                    nxt_r.st   = ST_WAIT_STATE;
                end else begin
                    nxt_r.st   = ST_THIRD_STATE;
                end
            end
            ST_THIRD_STATE: begin
                cyc_end = 1'b1;
            end
            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase

        // Read data is taken at the edge that closes the last state.
        if (cyc_end) begin
            lane_in = r_ff.ext ? i_data : i_int_rdata;
            acc     = r_ff.acc;
            if (!r_ff.wr) begin
                if (hi_use) begin
                    acc[8*(3-k) +: 8] = lane_in[15:8];
                end
                if (lo_use) begin
                    acc[8*(3-klo) +: 8] = lane_in[7:0];
                end
            end
            nxt_r.acc  = acc;
            nxt_r.wcnt = 2'h0;
            nboff      = r_ff.boff + bpc;
            if (nboff >= r_ff.nbytes) begin
                nxt_r.st    = ST_IDLE;
                nxt_r.done  = 1'b1;
                nxt_r.rdata = (r_ff.size == SZ_LONG) ? acc :
                              (r_ff.size == SZ_WORD) ?
                              {16'h0000, acc[31:16]} : {24'h00_0000, acc[31:24]};
            end else begin
                nxt_r.boff = nboff;
                nxt_r.st   = ST_T1;
            end
        end

        // A manual reset ends any cycle but leaves the settings alone.
        if (i_manual_rst) begin
            nxt_r.st   = ST_IDLE;
            nxt_r.done = 1'b0;
        end

        // Pin drive for the state about to start.
        act    = (nxt_r.st != ST_IDLE);
        a      = nxt_r.base + {21'h00_0000, nxt_r.boff};
        k      = nxt_r.boff[1:0];
        klo    = nxt_r.unit2 ? k + 2'h1 : k;
        hi_use = nxt_r.w8 | nxt_r.unit2 | ~a[0];
        lo_use = ~nxt_r.w8 & (nxt_r.unit2 | a[0]);
        nxt_r.busy    = act;
        nxt_r.addr    = act ? a : r_ff.addr;
        nxt_r.int_sel = act & ~nxt_r.ext;
        nxt_r.int_we  = act & ~nxt_r.ext & nxt_r.wr;
        nxt_r.rd_n    = ~(act & nxt_r.ext & ~nxt_r.wr);
        nxt_r.hwr_n   = ~(act & nxt_r.ext & nxt_r.wr & hi_use &
                          (nxt_r.st != ST_T1));
        nxt_r.lwr_n   = ~(act & nxt_r.ext & nxt_r.wr & lo_use &
                          (nxt_r.st != ST_T1));
        nxt_r.oe_hi   = act & nxt_r.ext & nxt_r.wr & hi_use;
        nxt_r.oe_lo   = act & nxt_r.ext & nxt_r.wr & lo_use;
        nxt_r.dout    = {hi_use ? byte_of(nxt_r.wdat, k)   : 8'h00,
                         lo_use ? byte_of(nxt_r.wdat, klo) : 8'h00};
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Power-on reset alone restores the defaults.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_ff <= RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_busy                 = r_ff.busy;
    assign o_done                 = r_ff.done;
    assign o_rdata                = r_ff.rdata;
    assign o_int_sel              = r_ff.int_sel;
    assign o_int_we               = r_ff.int_we;
    assign o_addr                 = r_ff.addr;
    assign o_rd_n                 = r_ff.rd_n;
    assign o_upper_write_strobe_n = r_ff.hwr_n;
    assign o_lower_write_strobe_n = r_ff.lwr_n;
    assign o_data                 = r_ff.dout;
    assign o_data_oe_hi           = r_ff.oe_hi;
    assign o_data_oe_lo           = r_ff.oe_lo;
    assign o_reg_rdata            = r_ff.reg_rdata;

endmodule : bebi_ctrl

`default_nettype wire

/* hw/bebi_pkg.sv */
// Purpose: Shared constants and types of the basic external bus interface.
// Assumes: One 20 MHz system clock, asynchronous active-low reset.
// Notes:   Register indices sit on a 3-bit plain register port.
package bebi_pkg;

    // ----------------------------------------------------------------
    // Register indices and values after power-on reset
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_AREA_WIDTH_CONTROL = 3'h0;
    localparam logic [2:0] REG_AREA_STATE_CONTROL = 3'h1;
    localparam logic [2:0] REG_WAIT_COUNT_HIGH    = 3'h2;
    localparam logic [2:0] REG_WAIT_COUNT_LOW     = 3'h3;
    localparam logic [2:0] REG_BUS_CONTROL        = 3'h4;
    localparam logic [2:0] REG_STATUS             = 3'h5;

    localparam logic [7:0] AWC_RST = 8'hFF;
    localparam logic [7:0] ASC_RST = 8'hFF;
    localparam logic [7:0] WCH_RST = 8'hFF;
    localparam logic [7:0] WCL_RST = 8'hFF;
    localparam logic       PWE_RST = 1'b0;

    // Bus control: pin wait enable bit position.
    localparam int unsigned PWE_BIT = 0;

    // ----------------------------------------------------------------
    // Request encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    localparam logic [1:0] SPACE_EXT    = 2'h0;
    localparam logic [1:0] SPACE_ONCHIP = 2'h1;
    localparam logic [1:0] SPACE_PERIPH = 2'h2;

    // Area number is taken from the top address bits.
    localparam int unsigned AREA_LSB = 21;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_SECOND_STATE,
        ST_WAIT_STATE,
        ST_THIRD_STATE
    } bebi_state_t;

endpackage : bebi_pkg

/* tb/bebi_ctrl_asserts.sv */
// Purpose: Port assertions for the external bus cycle generator.
// Assumes: Bound to bebi_ctrl; one clock domain.
// Notes:   Shadows the settings registers to know each area's mode.
`timescale 1ns/1ps
`default_nettype none

module bebi_ctrl_asserts
    import bebi_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic        i_manual_rst,
    input wire logic        i_req,
    input wire logic [1:0]  i_space,
    input wire logic [23:0] i_addr,
    input wire logic [1:0]  i_size,
    input wire logic [2:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic [23:0] o_addr,
    input wire logic        o_rd_n,
    input wire logic        o_upper_write_strobe_n,
    input wire logic        o_lower_write_strobe_n,
    input wire logic        o_data_oe_hi,
    input wire logic        o_data_oe_lo
);
    logic [7:0]  wid_ff;
    logic [7:0]  ast_ff;
    logic [15:0] wc_ff;
    logic        pwe_ff;
    logic        chk_ff;
    logic [3:0]  cnt_ff;
    logic [3:0]  exp_ff;
    logic [3:0]  nxt_exp;
    logic [2:0]  area;

    assign area = i_addr[23:21];

    // Pin waits stretch a cycle by an amount only the bench knows, so
    // length is checked here for single byte cycles without them.
    always_comb begin
        nxt_exp = 4'h2;
        if (i_space == SPACE_ONCHIP) begin
            nxt_exp = 4'h1;
        end else if (i_space == SPACE_EXT && ast_ff[area]) begin
            nxt_exp = 4'h3 + {2'h0, wc_ff[{area, 1'b0} +: 2]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wid_ff <= AWC_RST;
            ast_ff <= ASC_RST;
            wc_ff  <= {WCH_RST, WCL_RST};
            pwe_ff <= PWE_RST;
            chk_ff <= 1'b0;
            cnt_ff <= 4'h0;
            exp_ff <= 4'h0;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    REG_AREA_WIDTH_CONTROL: wid_ff <= i_reg_wdata;
                    REG_AREA_STATE_CONTROL: ast_ff <= i_reg_wdata;
                    REG_WAIT_COUNT_HIGH:    wc_ff[15:8] <= i_reg_wdata;
                    REG_WAIT_COUNT_LOW:     wc_ff[7:0] <= i_reg_wdata;
                    REG_BUS_CONTROL:        pwe_ff <= i_reg_wdata[PWE_BIT];
                    default: ;
                endcase
            end
            if (o_busy) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
            if (o_done || i_manual_rst) begin
                chk_ff <= 1'b0;
            end
            if (i_req && !o_busy && !i_manual_rst) begin
                chk_ff <= i_size == SZ_BYTE
                          && !(pwe_ff && ast_ff[area] && i_space == SPACE_EXT);
                cnt_ff <= 4'h0;
                exp_ff <= nxt_exp;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_next_cycle;
        o_busy && $past(o_busy) && o_addr != $past(o_addr);
    endsequence

    a_done_exact: assert property (o_done && chk_ff |-> cnt_ff == exp_ff)
        else $error("cycle length differs from area settings");
    a_done_prompt: assert property (o_busy && chk_ff |-> cnt_ff < exp_ff)
        else $error("transfer runs past its state count");
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    a_read_common: assert property (!o_rd_n |-> o_upper_write_strobe_n
        && o_lower_write_strobe_n && !o_data_oe_hi && !o_data_oe_lo)
        else $error("read strobe with write strobe or driven lane");
    a_narrow_low: assert property (!o_lower_write_strobe_n |->
        !wid_ff[o_addr[23:21]] && o_data_oe_lo)
        else $error("lower write strobe in 8-bit area or lane idle");
    a_upper_lane: assert property (!o_upper_write_strobe_n |->
        o_data_oe_hi && (wid_ff[o_addr[23:21]] || !o_addr[0]))
        else $error("upper write strobe on wrong lane");
    a_odd_lane: assert property (!o_lower_write_strobe_n
        && o_upper_write_strobe_n |-> o_addr[0] && !o_data_oe_hi)
        else $error("odd byte write uses upper lane");
    a_addr_ascend: assert property (s_next_cycle |->
        (o_addr - $past(o_addr)) inside {24'h00_0001, 24'h00_0002})
        else $error("split cycles not in ascending order");
    a_idle_quiet: assert property (!o_busy |-> o_rd_n
        && o_upper_write_strobe_n && o_lower_write_strobe_n)
        else $error("strobe active while idle");
endmodule // bebi_ctrl_asserts

bind bebi_ctrl bebi_ctrl_asserts u_asserts (.i_clk_sys, .i_rst_n,
    .i_manual_rst, .i_req, .i_space, .i_addr, .i_size, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .o_busy, .o_done, .o_addr, .o_rd_n,
    .o_upper_write_strobe_n, .o_lower_write_strobe_n, .o_data_oe_hi,
    .o_data_oe_lo);
`default_nettype wire

/* tb/bebi_mem_model.sv */
// Purpose: Behavioural ROM/SRAM on the external data lanes.
// Assumes: Low address byte selects a location; areas share storage.
// Notes:   Wait pin held low for a commanded number of read states.
`timescale 1ns/1ps
`default_nettype none

module bebi_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_rd_n,
    input  wire logic        i_upper_wr_n,
    input  wire logic        i_lower_wr_n,
    input  wire logic [15:0] i_data,
    input  wire logic [7:0]  i_width,
    input  wire logic [2:0]  i_stall,
    output logic [15:0]      o_data,
    output logic             o_wait_n
);
    logic [7:0]  mem [256];
    logic [15:0] last = 16'h0000;
    logic [2:0]  low_cnt = 3'h0;
    logic        narrow;
    logic [7:0]  ev;
    logic [15:0] rd_word;

    assign narrow = i_width[i_addr[23:21]];
    assign ev = {i_addr[7:1], 1'b0};
    assign rd_word = narrow ? {mem[i_addr[7:0]], ~mem[i_addr[7:0]]}
                            : {mem[ev], mem[ev | 8'h01]};
    // A released bus must not look like the last data read.
    assign o_data = i_rd_n ? ~last : rd_word;
    assign o_wait_n = !(low_cnt != 3'h0 && low_cnt <= i_stall);

    always_ff @(posedge i_clk_sys) begin
        low_cnt <= i_rd_n ? 3'h0 : low_cnt + {2'h0, low_cnt != 3'h7};
        if (!i_rd_n) begin
            last <= rd_word;
        end
        if (!i_upper_wr_n) begin
            mem[narrow ? i_addr[7:0] : ev] <= i_data[15:8];
        end
        if (!i_lower_wr_n) begin
            mem[ev | 8'h01] <= i_data[7:0];
        end
    end
endmodule // bebi_mem_model
`default_nettype wire

/* tb/bebi_tb_top.sv */
// Purpose: Self-checking bench of the external bus cycle generator.
// Assumes: Memory model on the external lanes, constant internal data.
// Notes:   Cycle counts are edges from request taken to done.
`timescale 1ns/1ps
`default_nettype none

module bebi_tb_top;
    import bebi_pkg::*;
    logic        clk, rst_n, man_rst, req, wide, wr, reg_we, reg_re;
    logic        busy, done, rd_n, uw_n, lw_n, oe_hi, oe_lo, wait_n;
    logic [1:0]  space, size;
    logic [2:0]  reg_addr, stall;
    logic [7:0]  reg_wdata, reg_rdata, width;
    logic [15:0] dout, mem_out, bus;
    logic [23:0] addr, ext_addr;
    logic [31:0] wdata, rdata, rd;
    int          fails, tests_run, n;
    logic [23:0] abase [3] = '{24'h00_0010, 24'h20_0020, 24'h40_0030};
    logic [31:0] lval [3] = '{32'h1122_3344, 32'h5566_7788, 32'h99AA_BBCC};
    logic [31:0] lcyc [3] = '{32'h0000_0005, 32'h0000_000D, 32'h0000_000D};

    assign bus = {oe_hi ? dout[15:8] : mem_out[15:8],
                  oe_lo ? dout[7:0] : mem_out[7:0]};

    bebi_ctrl DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_manual_rst(man_rst),
        .i_req(req), .i_space(space), .i_periph_wide(wide), .i_addr(addr),
        .i_wr(wr), .i_size(size), .i_wdata(wdata), .o_busy(busy),
        .o_done(done), .o_rdata(rdata), .o_int_sel(), .o_int_we(),
        .i_int_rdata(16'hA55A), .o_addr(ext_addr), .o_rd_n(rd_n),
        .o_upper_write_strobe_n(uw_n), .o_lower_write_strobe_n(lw_n),
        .o_data(dout), .o_data_oe_hi(oe_hi), .o_data_oe_lo(oe_lo),
        .i_data(bus), .i_wait_n(wait_n), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_we), .i_reg_rd(reg_re),
        .o_reg_rdata(reg_rdata));

    bebi_mem_model u_mem (.i_clk_sys(clk), .i_addr(ext_addr), .i_rd_n(rd_n),
        .i_upper_wr_n(uw_n), .i_lower_wr_n(lw_n), .i_data(bus),
        .i_width(width), .i_stall(stall), .o_data(mem_out), .o_wait_n(wait_n));

    always #25 clk = ~clk;

    task automatic end_of_test();
        $display("counts: %0d checks, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        if (a == REG_AREA_WIDTH_CONTROL) width = d;
    endtask

    task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 check({24'h0, reg_rdata}, {24'h0, e});
    endtask

    // Bounded wait: a transfer that never finishes ends the run.
    task automatic xfer(input logic [1:0] sp, input logic [23:0] a,
        input logic w, input logic [1:0] sz, input logic [31:0] d);
        @(posedge clk);
        space <= sp;
        addr <= a;
        wr <= w;
        size <= sz;
        wdata <= d;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 60) begin
            fails++;
            end_of_test();
        end
        rd = rdata;
    endtask

    function automatic logic [31:0] mem32(input logic [7:0] a);
        return {u_mem.mem[a], u_mem.mem[a + 8'h01],
                u_mem.mem[a + 8'h02], u_mem.mem[a + 8'h03]};
    endfunction

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {man_rst, req, wide, wr, reg_we, reg_re} = '0;
        {space, size, addr, wdata, reg_wdata, reg_addr, stall} = '0;
        width = AWC_RST;
        fails = 0;
        tests_run = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(REG_AREA_WIDTH_CONTROL, AWC_RST);
        reg_rd(REG_AREA_STATE_CONTROL, ASC_RST);
        reg_rd(REG_WAIT_COUNT_HIGH, WCH_RST);
        reg_rd(REG_WAIT_COUNT_LOW, WCL_RST);
        reg_rd(REG_BUS_CONTROL, {7'h00, PWE_RST});
        reg_rd(3'h6, 8'h00);
        $display("test reset_values done");
        reg_wr(REG_AREA_WIDTH_CONTROL, 8'hFA);
        reg_wr(REG_AREA_STATE_CONTROL, 8'hFE);
        reg_wr(REG_WAIT_COUNT_LOW, 8'hF0);
        for (int i = 0; i < 3; i++) begin
            xfer(SPACE_EXT, abase[i], 1'b1, SZ_LONG, lval[i]);
            check(32'(n), lcyc[i]);
            check(mem32(abase[i][7:0]), lval[i]);
            xfer(SPACE_EXT, abase[i], 1'b0, SZ_LONG, 32'h0000_0000);
            check(rd, lval[i]);
            check(32'(n), lcyc[i]);
        end
        $display("test long_transfers done");
        xfer(SPACE_EXT, 24'h00_0041, 1'b1, SZ_BYTE, 32'h0000_00AB);
        xfer(SPACE_EXT, 24'h00_0040, 1'b1, SZ_BYTE, 32'h0000_00CD);
        check(mem32(8'h40) >> 16, 32'h0000_CDAB);
        xfer(SPACE_EXT, 24'h00_0041, 1'b0, SZ_BYTE, 32'h0000_0000);
        check(rd, 32'h0000_00AB);
        check(32'(n), 32'h0000_0003);
        xfer(SPACE_EXT, 24'h00_0040, 1'b0, SZ_WORD, 32'h0000_0000);
        check(rd, 32'h0000_CDAB);
        xfer(SPACE_EXT, 24'h20_0050, 1'b1, SZ_WORD, 32'h0000_5566);
        check(mem32(8'h50) >> 16, 32'h0000_5566);
        check(32'(n), 32'h0000_0007);
        $display("test byte_lanes done");
        reg_wr(REG_BUS_CONTROL, 8'h01);
        stall = 3'h2;
        xfer(SPACE_EXT, 24'h20_0020, 1'b0, SZ_BYTE, 32'h0000_0000);
        check(rd, 32'h0000_0055);
        check(32'(n), 32'h0000_0006);
        xfer(SPACE_EXT, 24'h00_0010, 1'b0, SZ_BYTE, 32'h0000_0000);
        check(32'(n), 32'h0000_0003);
        stall = 3'h5;
        xfer(SPACE_EXT, 24'h40_0030, 1'b0, SZ_BYTE, 32'h0000_0000);
        check(32'(n), 32'h0000_0009);
        stall = 3'h0;
        reg_wr(REG_BUS_CONTROL, 8'h00);
        $display("test pin_waits done");
        xfer(SPACE_ONCHIP, 24'h00_0100, 1'b0, SZ_WORD, 32'h0000_0000);
        check(rd, 32'h0000_A55A);
        check(32'(n), 32'h0000_0002);
        wide = 1'b1;
        xfer(SPACE_PERIPH, 24'h00_0200, 1'b0, SZ_WORD, 32'h0000_0000);
        check(rd, 32'h0000_A55A);
        check(32'(n), 32'h0000_0003);
        wide = 1'b0;
        xfer(SPACE_PERIPH, 24'h00_0200, 1'b0, SZ_WORD, 32'h0000_0000);
        check(32'(n), 32'h0000_0005);
        $display("test internal done");
        @(posedge clk);
        space <= SPACE_EXT;
        addr <= 24'h20_0020;
        size <= SZ_LONG;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
        man_rst <= 1'b1;
        @(posedge clk);
        man_rst <= 1'b0;
        @(posedge clk);
        #1 check({31'h0, busy}, 32'h0000_0000);
        reg_rd(REG_WAIT_COUNT_LOW, 8'hF0);
        xfer(SPACE_EXT, 24'h40_0030, 1'b0, SZ_BYTE, 32'h0000_0000);
        check(rd, 32'h0000_0099);
        check(32'(n), 32'h0000_0007);
        $display("test manual_reset done");
        end_of_test();
    end
endmodule // bebi_tb_top
`default_nettype wire
